// ### core/mppt_i2c_pkg.sv
// Constants, field layouts and state types of the I2C register port.
// Assumes a 25 MHz system clock and an external master at 100 kHz.
//
// Summary of operation
// - Trim register: four 8-bit offsets, reset zero
// - Compare currents against thresholds to gate tracking
// - Input upper threshold bits 39:30, reset 40
// - Input lower threshold bits 29:20, reset 24
// - Output upper threshold bits 19:10, reset 40
// - Output lower threshold bits 9:0, reset 24
// - Slave address from three strap pins
// - Clock line input only; data driven for acks/reads
// - Command byte E0 plus register number selects
// - Registers 0,1 read-only; 3,4,5 read/write
// - Writes commit only after seven data bytes; reads send at most seven
// - Read bytes returned least significant first

package mppt_i2c_pkg;

	////////////////////////////////////////////////////////////////////////////
	// Command and register selection

	localparam logic [7:0] CMD_BASE    = 8'hE0;
	localparam logic [2:0] REG_STATUS0 = 3'h0;
	localparam logic [2:0] REG_STATUS1 = 3'h1;
	localparam logic [2:0] REG_CONTROL = 3'h3;
	localparam logic [2:0] REG_TRIM    = 3'h4;
	localparam logic [2:0] REG_THRESH  = 3'h5;

	////////////////////////////////////////////////////////////////////////////
	// Transfer shape

	localparam int         REG_BITS      = 56;
	localparam int         BYTE_BITS     = 8;
	localparam logic [2:0] BYTES_PER_REG = 3'h7;
	localparam logic [3:0] BIT_LAST      = 4'h8;
	localparam logic [3:0] ADDR_PAD      = 4'h0;
	localparam int         SCL_RATE_HZ   = 100000;
	localparam int         CLK_HZ        = 25000000;

	////////////////////////////////////////////////////////////////////////////
	// Field layouts

	localparam int TRIM_WIDTH     = 8;
	localparam int TRIM_USED_BITS = 32;
	localparam int TRIM_VOUT_LSB  = 24;
	localparam int TRIM_IOUT_LSB  = 16;
	localparam int TRIM_VIN_LSB   = 8;
	localparam int TRIM_IIN_LSB   = 0;

	localparam int TH_WIDTH       = 10;
	localparam int TH_USED_BITS   = 40;
	localparam int TH_IIN_HI_LSB  = 30;
	localparam int TH_IIN_LO_LSB  = 20;
	localparam int TH_IOUT_HI_LSB = 10;
	localparam int TH_IOUT_LO_LSB = 0;

	////////////////////////////////////////////////////////////////////////////
	// Reset values

	localparam logic [31:0] TRIM_RESET    = 32'h00000000;
	localparam logic [39:0] THRESH_RESET  = {10'h028, 10'h018, 10'h028, 10'h018};
	localparam logic [55:0] CONTROL_RESET = 56'h0000FFFFF6DFE0;

	////////////////////////////////////////////////////////////////////////////
	// State types

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_RX,
		ST_RX_ACK,
		ST_TX,
		ST_TX_ACK
	} link_state_e;

	typedef enum logic [1:0] {
		PH_ADDR,
		PH_CMD,
		PH_WDATA
	} byte_phase_e;

endpackage : mppt_i2c_pkg

// ### core/mppt_start_compare.sv
// Start/stop decision for tracking from the two current readings.
// Assumes readings come from converter logic on the same clock.
`timescale 1ns/1ps

module mppt_start_compare #(
	parameter int W = 10
) (
	input  wire logic         clk,
	input  wire logic         reset_n,
	input  wire logic [W-1:0] input_current,
	input  wire logic [W-1:0] output_current,
	input  wire logic [W-1:0] input_current_start_upper,
	input  wire logic [W-1:0] input_current_start_lower,
	input  wire logic [W-1:0] output_current_start_upper,
	input  wire logic [W-1:0] output_current_start_lower,
	output logic              tracking_r
);

	// Hysteresis: the gap between upper and lower stops chatter at the edge
	wire enter_cond = (input_current >= input_current_start_upper) ||
	                  (output_current >= output_current_start_upper);
	wire leave_cond = (input_current < input_current_start_lower) &&
	                  (output_current < output_current_start_lower);

	logic tracking_nxt;
	assign tracking_nxt = enter_cond ? 1'b1 : (leave_cond ? 1'b0 : tracking_r);

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			tracking_r <= 1'b0;
		end else begin
			tracking_r <= tracking_nxt;
		end
	end

endmodule : mppt_start_compare

// ### core/mppt_i2c_register_port.sv
// I2C slave register port with the trim, threshold and control registers.
// Assumes open-drain bus pins resolved outside, master at 100 kHz.
`timescale 1ns/1ps

module mppt_i2c_register_port (
	input  wire logic        clk,
	input  wire logic        reset_n,
	input  wire logic        scl_in,
	input  wire logic        sda_in,
	output logic             sda_out,
	output logic             sda_oe,
	input  wire logic        slave_addr_strap_msb,
	input  wire logic        slave_addr_strap_mid,
	input  wire logic        slave_addr_strap_lsb,
	input  wire logic [55:0] status_word0,
	input  wire logic [55:0] status_word1,
	input  wire logic [9:0]  input_current_sense_pin,
	input  wire logic [9:0]  output_current_sense_pin,
	output logic [55:0]      control_word,
	output logic [7:0]       vout_offset,
	output logic [7:0]       iout_offset,
	output logic [7:0]       vin_offset,
	output logic [7:0]       iin_offset,
	output logic [9:0]       input_current_start_upper,
	output logic [9:0]       input_current_start_lower,
	output logic [9:0]       output_current_start_upper,
	output logic [9:0]       output_current_start_lower,
	output logic             tracking_enable
);

	////////////////////////////////////////////////////////////////////////////
	// Pin synchronisers

	logic       scl_s1_r;
	logic       scl_s2_r;
	logic       scl_d_r;
	logic       sda_s1_r;
	logic       sda_s2_r;
	logic       sda_d_r;
	logic [2:0] strap_s1_r;
	logic [2:0] strap_s2_r;

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			scl_s1_r <= 1'b1;
			scl_s2_r <= 1'b1;
			scl_d_r  <= 1'b1;
			sda_s1_r <= 1'b1;
			sda_s2_r <= 1'b1;
			sda_d_r  <= 1'b1;
		end else begin
			scl_s1_r <= scl_in;
			scl_s2_r <= scl_s1_r;
			scl_d_r  <= scl_s2_r;
			sda_s1_r <= sda_in;
			sda_s2_r <= sda_s1_r;
			sda_d_r  <= sda_s2_r;
		end
	end

	// Straps are static; tracked continuously rather than latched once
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			strap_s1_r <= 3'h0;
			strap_s2_r <= 3'h0;
		end else begin
			strap_s1_r <= {slave_addr_strap_msb, slave_addr_strap_mid,
			               slave_addr_strap_lsb};
			strap_s2_r <= strap_s1_r;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Bus events

	wire scl_rise  = scl_s2_r & ~scl_d_r;
	wire scl_fall  = ~scl_s2_r & scl_d_r;
	wire start_det = scl_s2_r & scl_d_r & sda_d_r & ~sda_s2_r;
	wire stop_det  = scl_s2_r & scl_d_r & ~sda_d_r & sda_s2_r;

	////////////////////////////////////////////////////////////////////////////
	// State

	mppt_i2c_pkg::link_state_e state_r;
	mppt_i2c_pkg::link_state_e state_nxt;
	mppt_i2c_pkg::byte_phase_e phase_r;
	mppt_i2c_pkg::byte_phase_e phase_nxt;
	logic [3:0]                bit_cnt_r;
	logic [3:0]                bit_cnt_nxt;
	logic [7:0]                shift_r;
	logic [7:0]                shift_nxt;
	logic [7:0]                tx_r;
	logic [7:0]                tx_nxt;
	logic [2:0]                idx_r;
	logic [2:0]                idx_nxt;
	logic [2:0]                sel_r;
	logic [2:0]                sel_nxt;
	logic                      rw_r;
	logic                      rw_nxt;
	logic                      master_ack_r;
	logic                      master_ack_nxt;
	logic                      sda_oe_r;
	logic                      sda_oe_nxt;
	logic                      sda_out_r;
	logic [55:0]               wbuf_r;
	logic [55:0]               control_r;
	logic [31:0]               trim_r;
	logic [39:0]               thresh_r;

	////////////////////////////////////////////////////////////////////////////
	// Decode

	wire       addr_match = (shift_r[7:1] == {mppt_i2c_pkg::ADDR_PAD, strap_s2_r});
	wire [7:0] cmd_off    = shift_r - mppt_i2c_pkg::CMD_BASE;
	wire       cmd_known  = (cmd_off[2:0] == mppt_i2c_pkg::REG_STATUS0) ||
	                        (cmd_off[2:0] == mppt_i2c_pkg::REG_STATUS1) ||
	                        (cmd_off[2:0] == mppt_i2c_pkg::REG_CONTROL) ||
	                        (cmd_off[2:0] == mppt_i2c_pkg::REG_TRIM) ||
	                        (cmd_off[2:0] == mppt_i2c_pkg::REG_THRESH);
	wire       cmd_valid  = (cmd_off[7:3] == 5'h00) && cmd_known;
	// An eighth data byte is refused so no partial register follows
	wire       room_left  = (idx_r != mppt_i2c_pkg::BYTES_PER_REG);
	wire       byte_done  = (bit_cnt_r == mppt_i2c_pkg::BIT_LAST);

	logic rx_ack_ok;
	always_comb begin
		unique case (phase_r)
			mppt_i2c_pkg::PH_ADDR:  rx_ack_ok = addr_match;
			mppt_i2c_pkg::PH_CMD:   rx_ack_ok = cmd_valid;
			mppt_i2c_pkg::PH_WDATA: rx_ack_ok = room_left;
			default:                rx_ack_ok = 1'b0;
		endcase
	end

	logic [55:0] rd_word;
	always_comb begin
		unique case (sel_r)
			mppt_i2c_pkg::REG_STATUS0: rd_word = status_word0;
			mppt_i2c_pkg::REG_STATUS1: rd_word = status_word1;
			mppt_i2c_pkg::REG_CONTROL: rd_word = control_r;
			mppt_i2c_pkg::REG_TRIM:
				rd_word = {{(mppt_i2c_pkg::REG_BITS - mppt_i2c_pkg::TRIM_USED_BITS){1'b0}},
				           trim_r};
			mppt_i2c_pkg::REG_THRESH:
				rd_word = {{(mppt_i2c_pkg::REG_BITS - mppt_i2c_pkg::TH_USED_BITS){1'b0}},
				           thresh_r};
			default:                   rd_word = 56'h00000000000000;
		endcase
	end

	// Least significant byte goes first, indexed by bytes already sent
	wire [5:0] rd_lsb  = {idx_r, 3'h0};
	wire [7:0] rd_byte = rd_word[rd_lsb +: mppt_i2c_pkg::BYTE_BITS];

	// Write lands only once the seventh byte's acknowledge is complete
	wire commit = (state_r == mppt_i2c_pkg::ST_RX_ACK) && scl_fall &&
	              (phase_r == mppt_i2c_pkg::PH_WDATA) &&
	              (idx_r == mppt_i2c_pkg::BYTES_PER_REG);

	////////////////////////////////////////////////////////////////////////////
	// Byte engine

	always_comb begin
		state_nxt      = state_r;
		phase_nxt      = phase_r;
		bit_cnt_nxt    = bit_cnt_r;
		shift_nxt      = shift_r;
		tx_nxt         = tx_r;
		idx_nxt        = idx_r;
		sel_nxt        = sel_r;
		rw_nxt         = rw_r;
		master_ack_nxt = master_ack_r;
		sda_oe_nxt     = sda_oe_r;
		if (stop_det) begin
			state_nxt  = mppt_i2c_pkg::ST_IDLE;
			sda_oe_nxt = 1'b0;
		end else if (start_det) begin
			state_nxt   = mppt_i2c_pkg::ST_RX;
			phase_nxt   = mppt_i2c_pkg::PH_ADDR;
			bit_cnt_nxt = 4'h0;
			sda_oe_nxt  = 1'b0;
		end else begin
			unique case (state_r)
				mppt_i2c_pkg::ST_IDLE: begin
					sda_oe_nxt = 1'b0;
				end
				mppt_i2c_pkg::ST_RX: begin
					if (scl_rise && !byte_done) begin
						shift_nxt   = {shift_r[6:0], sda_s2_r};
						bit_cnt_nxt = bit_cnt_r + 4'h1;
					end else if (scl_fall && byte_done) begin
						if (rx_ack_ok) begin
							state_nxt  = mppt_i2c_pkg::ST_RX_ACK;
							sda_oe_nxt = 1'b1;
							unique case (phase_r)
								mppt_i2c_pkg::PH_ADDR: begin
									rw_nxt  = shift_r[0];
									idx_nxt = 3'h0;
								end
								mppt_i2c_pkg::PH_CMD: begin
									sel_nxt = cmd_off[2:0];
									idx_nxt = 3'h0;
								end
								mppt_i2c_pkg::PH_WDATA: begin
									idx_nxt = idx_r + 3'h1;
								end
							endcase
						end else begin
							state_nxt = mppt_i2c_pkg::ST_IDLE;
						end
					end
				end
				mppt_i2c_pkg::ST_RX_ACK: begin
					if (scl_fall) begin
						bit_cnt_nxt = 4'h0;
						if (phase_r == mppt_i2c_pkg::PH_ADDR && rw_r) begin
							state_nxt  = mppt_i2c_pkg::ST_TX;
							tx_nxt     = rd_byte;
							sda_oe_nxt = ~rd_byte[7];
							idx_nxt    = idx_r + 3'h1;
						end else begin
							state_nxt  = mppt_i2c_pkg::ST_RX;
							sda_oe_nxt = 1'b0;
							if (phase_r == mppt_i2c_pkg::PH_ADDR) begin
								phase_nxt = mppt_i2c_pkg::PH_CMD;
							end else begin
								phase_nxt = mppt_i2c_pkg::PH_WDATA;
							end
						end
					end
				end
				mppt_i2c_pkg::ST_TX: begin
					if (scl_rise) begin
						bit_cnt_nxt = bit_cnt_r + 4'h1;
					end else if (scl_fall) begin
						if (byte_done) begin
							state_nxt  = mppt_i2c_pkg::ST_TX_ACK;
							sda_oe_nxt = 1'b0;
						end else begin
							tx_nxt     = {tx_r[6:0], 1'b0};
							sda_oe_nxt = ~tx_r[6];
						end
					end
				end
				mppt_i2c_pkg::ST_TX_ACK: begin
					if (scl_rise) begin
						master_ack_nxt = ~sda_s2_r;
					end else if (scl_fall) begin
						// Stops after seven bytes even if the master keeps acking
						if (master_ack_r && room_left) begin
							state_nxt   = mppt_i2c_pkg::ST_TX;
							tx_nxt      = rd_byte;
							sda_oe_nxt  = ~rd_byte[7];
							idx_nxt     = idx_r + 3'h1;
							bit_cnt_nxt = 4'h0;
						end else begin
							state_nxt = mppt_i2c_pkg::ST_IDLE;
						end
					end
				end
			endcase
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			state_r      <= mppt_i2c_pkg::ST_IDLE;
			phase_r      <= mppt_i2c_pkg::PH_ADDR;
			bit_cnt_r    <= 4'h0;
			shift_r      <= 8'h00;
			tx_r         <= 8'h00;
			idx_r        <= 3'h0;
			sel_r        <= mppt_i2c_pkg::REG_STATUS0;
			rw_r         <= 1'b0;
			master_ack_r <= 1'b0;
			sda_oe_r     <= 1'b0;
			sda_out_r    <= 1'b0;
		end else begin
			state_r      <= state_nxt;
			phase_r      <= phase_nxt;
			bit_cnt_r    <= bit_cnt_nxt;
			shift_r      <= shift_nxt;
			tx_r         <= tx_nxt;
			idx_r        <= idx_nxt;
			sel_r        <= sel_nxt;
			rw_r         <= rw_nxt;
			master_ack_r <= master_ack_nxt;
			sda_oe_r     <= sda_oe_nxt;
			sda_out_r    <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Write staging and registers

	wire       wbuf_load = (state_r == mppt_i2c_pkg::ST_RX) && scl_fall && byte_done &&
	                       (phase_r == mppt_i2c_pkg::PH_WDATA) && room_left;
	wire [5:0] wr_lsb    = {idx_r, 3'h0};

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			wbuf_r <= 56'h00000000000000;
		end else if (wbuf_load) begin
			wbuf_r[wr_lsb +: mppt_i2c_pkg::BYTE_BITS] <= shift_r;
		end
	end

	// Status selections get no write strobe from commit, so writes to them vanish
	wire wr_control = commit && (sel_r == mppt_i2c_pkg::REG_CONTROL);
	wire wr_trim    = commit && (sel_r == mppt_i2c_pkg::REG_TRIM);
	wire wr_thresh  = commit && (sel_r == mppt_i2c_pkg::REG_THRESH);

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			control_r <= mppt_i2c_pkg::CONTROL_RESET;
			trim_r    <= mppt_i2c_pkg::TRIM_RESET;
			thresh_r  <= mppt_i2c_pkg::THRESH_RESET;
		end else begin
			if (wr_control) begin
				control_r <= wbuf_r;
			end
			if (wr_trim) begin
				trim_r <= wbuf_r[mppt_i2c_pkg::TRIM_USED_BITS-1:0];
			end
			if (wr_thresh) begin
				thresh_r <= wbuf_r[mppt_i2c_pkg::TH_USED_BITS-1:0];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Outputs

	assign sda_out      = sda_out_r;
	assign sda_oe       = sda_oe_r;
	assign control_word = control_r;
	assign vout_offset  = trim_r[mppt_i2c_pkg::TRIM_VOUT_LSB +: mppt_i2c_pkg::TRIM_WIDTH];
	assign iout_offset  = trim_r[mppt_i2c_pkg::TRIM_IOUT_LSB +: mppt_i2c_pkg::TRIM_WIDTH];
	assign vin_offset   = trim_r[mppt_i2c_pkg::TRIM_VIN_LSB +: mppt_i2c_pkg::TRIM_WIDTH];
	assign iin_offset   = trim_r[mppt_i2c_pkg::TRIM_IIN_LSB +: mppt_i2c_pkg::TRIM_WIDTH];
	assign input_current_start_upper =
		thresh_r[mppt_i2c_pkg::TH_IIN_HI_LSB +: mppt_i2c_pkg::TH_WIDTH];
	assign input_current_start_lower =
		thresh_r[mppt_i2c_pkg::TH_IIN_LO_LSB +: mppt_i2c_pkg::TH_WIDTH];
	assign output_current_start_upper =
		thresh_r[mppt_i2c_pkg::TH_IOUT_HI_LSB +: mppt_i2c_pkg::TH_WIDTH];
	assign output_current_start_lower =
		thresh_r[mppt_i2c_pkg::TH_IOUT_LO_LSB +: mppt_i2c_pkg::TH_WIDTH];

	mppt_start_compare #(
		.W (mppt_i2c_pkg::TH_WIDTH)
	) u_start_compare (
		.clk                        (clk),
		.reset_n                    (reset_n),
		.input_current              (input_current_sense_pin),
		.output_current             (output_current_sense_pin),
		.input_current_start_upper  (input_current_start_upper),
		.input_current_start_lower  (input_current_start_lower),
		.output_current_start_upper (output_current_start_upper),
		.output_current_start_lower (output_current_start_lower),
		.tracking_r                 (tracking_enable)
	);

endmodule : mppt_i2c_register_port

// ### sim/mppt_i2c_register_port_checker.sv
// Pin-level assertions for the I2C register port.
// Assumes it is bound onto the port module; single clock domain.
`timescale 1ns/1ps

module mppt_i2c_register_port_checker (
	input wire logic       clk,
	input wire logic       reset_n,
	input wire logic       scl_in,
	input wire logic       sda_out,
	input wire logic       sda_oe,
	input wire logic [7:0] vout_offset,
	input wire logic [7:0] iout_offset,
	input wire logic [7:0] vin_offset,
	input wire logic [7:0] iin_offset,
	input wire logic [9:0] input_current_start_upper,
	input wire logic [9:0] input_current_start_lower,
	input wire logic [9:0] output_current_start_upper,
	input wire logic [9:0] output_current_start_lower,
	input wire logic [9:0] input_current_sense_pin,
	input wire logic [9:0] output_current_sense_pin,
	input wire logic       tracking_enable
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!reset_n);

	wire logic [31:0] trim_w = {vout_offset, iout_offset, vin_offset, iin_offset};
	wire logic [39:0] th_w   = {input_current_start_upper, input_current_start_lower,
		output_current_start_upper, output_current_start_lower};
	wire logic        enter_w = (input_current_sense_pin >= input_current_start_upper)
		|| (output_current_sense_pin >= output_current_start_upper);
	wire logic        exit_w  = (input_current_sense_pin < input_current_start_lower)
		&& (output_current_sense_pin < output_current_start_lower);

	////////////////////////////////////////////////////////////
	a_trim_reset: assert property ($rose(reset_n) |-> trim_w == 32'h0)
		else $error("trim fields not zero after reset");
	a_in_th_reset: assert property ($rose(reset_n) |-> th_w[39:20] == {10'h028, 10'h018})
		else $error("input thresholds wrong after reset");
	a_out_th_reset: assert property ($rose(reset_n) |-> th_w[19:0] == {10'h028, 10'h018})
		else $error("output thresholds wrong after reset");
	a_track_enter: assert property (enter_w |=> tracking_enable)
		else $error("tracking not entered");
	a_track_exit: assert property (exit_w && !enter_w |=> !tracking_enable)
		else $error("tracking not left");
	a_track_hold: assert property (!exit_w && !enter_w |=> $stable(tracking_enable))
		else $error("tracking changed inside hysteresis band");
	a_oe_scl_low: assert property ($changed(sda_oe) |-> !scl_in && !$past(scl_in))
		else $error("data line drive changed while clock high");
	a_open_drain: assert property (sda_oe |-> sda_out == 1'b0)
		else $error("data line driven high");
	a_regs_scl_low: assert property ($changed({trim_w, th_w}) |-> !scl_in && !$past(scl_in))
		else $error("register changed outside a clock-low phase");

	c_track_on: cover property ($rose(tracking_enable));
	c_track_off: cover property ($fell(tracking_enable));
	c_trim_wr: cover property ($changed(trim_w));
	c_ack: cover property ($rose(sda_oe));
endmodule : mppt_i2c_register_port_checker

// ### sim/mppt_i2c_master_model.sv
// Bus master model: drives the clock line, pulls the data line low.
// Assumes the bench resolves the data wire with a pull-up.
`timescale 1ns/1ps

module mppt_i2c_master_model #(
	parameter int QTR = 63
) (
	input  wire logic clk,
	input  wire logic sda,
	output logic      scl,
	output logic      sda_pull
);
	initial begin
		scl = 1'b1;
		sda_pull = 1'b0;
	end

	// Quarter bit of 63 clocks keeps the bus just under 100 kHz
	task automatic tick();
		repeat (QTR) @(posedge clk);
	endtask : tick

	task automatic put_bit(input logic b, output logic r);
		sda_pull <= !b;
		tick();
		scl <= 1'b1;
		tick();
		r = sda;
		tick();
		scl <= 1'b0;
		tick();
	endtask : put_bit

	task automatic send_start();
		sda_pull <= 1'b0;
		tick();
		scl <= 1'b1;
		tick();
		sda_pull <= 1'b1;
		tick();
		scl <= 1'b0;
		tick();
	endtask : send_start

	task automatic send_stop();
		sda_pull <= 1'b1;
		tick();
		scl <= 1'b1;
		tick();
		sda_pull <= 1'b0;
		tick();
	endtask : send_stop

	task automatic put_byte(input logic [7:0] d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			put_bit(d[i], r);
		end
		put_bit(1'b1, r);
		ack = !r;
	endtask : put_byte

	task automatic get_byte(input logic last, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			put_bit(1'b1, d[i]);
		end
		put_bit(last, r);
	endtask : get_byte

	task automatic write_reg(input logic [6:0] a, input logic [7:0] cmd,
		input logic [55:0] d, input int n, output int acks);
		logic ok;
		acks = 0;
		send_start();
		put_byte({a, 1'b0}, ok);
		acks += int'(ok);
		if (ok) begin
			put_byte(cmd, ok);
			acks += int'(ok);
			for (int k = 0; k < n; k++) begin
				put_byte(d[8*k +: 8], ok);
				acks += int'(ok);
			end
		end
		send_stop();
	endtask : write_reg

	task automatic read_reg(input logic [6:0] a, input logic [7:0] cmd,
		output logic [55:0] d, output int acks);
		logic       ok;
		logic [7:0] b;
		acks = 0;
		send_start();
		put_byte({a, 1'b0}, ok);
		acks += int'(ok);
		put_byte(cmd, ok);
		acks += int'(ok);
		send_start();
		put_byte({a, 1'b1}, ok);
		acks += int'(ok);
		for (int k = 0; k < 7; k++) begin
			get_byte(k == 6, b);
			d[8*k +: 8] = b;
		end
		send_stop();
	endtask : read_reg
endmodule : mppt_i2c_master_model

// ### sim/mppt_i2c_register_port_tb_top.sv
// Self-checking bench for the I2C register port.
// Assumes the master model and checker files are compiled first.
`timescale 1ns/1ps

module mppt_i2c_register_port_tb_top;
	localparam logic [6:0] DEV = 7'h06;
	// Distinct bytes so a swapped byte order cannot pass
	localparam logic [55:0] STATUS0 = 56'h77665544332211;
	logic [55:0] ctl;
	logic        clk;
	logic        reset_n;
	logic        scl;
	logic        m_pull;
	logic [2:0]  strap;
	logic [9:0]  iin_s;
	logic [9:0]  iout_s;
	logic        sda_out;
	logic        sda_oe;
	logic [7:0]  vo, io, vi, ii;
	logic [9:0]  t_iu, t_il, t_ou, t_ol;
	logic        trk;
	int          err_total;
	int          compares;
	wire logic   sda_w = !(m_pull || (sda_oe && !sda_out));

	mppt_i2c_master_model u_m (.clk(clk), .sda(sda_w), .scl(scl), .sda_pull(m_pull));

	mppt_i2c_register_port u_dut (.clk(clk), .reset_n(reset_n), .scl_in(scl),
		.sda_in(sda_w), .sda_out(sda_out), .sda_oe(sda_oe),
		.slave_addr_strap_msb(strap[2]), .slave_addr_strap_mid(strap[1]),
		.slave_addr_strap_lsb(strap[0]), .status_word0(STATUS0), .status_word1(56'h0),
		.input_current_sense_pin(iin_s), .output_current_sense_pin(iout_s),
		.control_word(ctl), .vout_offset(vo), .iout_offset(io), .vin_offset(vi),
		.iin_offset(ii), .input_current_start_upper(t_iu),
		.input_current_start_lower(t_il), .output_current_start_upper(t_ou),
		.output_current_start_lower(t_ol), .tracking_enable(trk));

	always #20 clk = !clk;

	task automatic chk(input logic [55:0] got, input logic [55:0] exp);
		compares++;
		if (got !== exp) begin
			err_total++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task automatic complete_run();
		$display("compares=%0d err_total=%0d", compares, err_total);
		if (err_total == 0 && compares > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : complete_run

	////////////////////////////////////////////////////////////
	task automatic t_reset_values();
		chk({24'h0, vo, io, vi, ii}, 56'h0);
		chk(ctl, 56'h0000FFFFF6DFE0);
		chk({16'h0, t_iu, t_il, t_ou, t_ol}, {16'h0, 10'd40, 10'd24, 10'd40, 10'd24});
	endtask : t_reset_values

	// Hysteresis walk across both boundaries of both readings
	task automatic t_tracking();
		logic [20:0] tab [6] = '{{10'd40, 10'd0, 1'b1}, {10'd24, 10'd0, 1'b1},
			{10'd23, 10'd0, 1'b0}, {10'd39, 10'd39, 1'b0}, {10'd0, 10'd40, 1'b1},
			{10'd0, 10'd23, 1'b0}};
		foreach (tab[k]) begin
			iin_s <= tab[k][20:11];
			iout_s <= tab[k][10:1];
			repeat (3) @(posedge clk);
			chk({55'h0, trk}, {55'h0, tab[k][0]});
		end
	endtask : t_tracking

	task automatic t_read_thresholds();
		logic [55:0] d;
		int          acks;
		u_m.read_reg(DEV, 8'hE5, d, acks);
		chk(56'(acks), 56'h3);
		chk(d, {16'h0, 10'd40, 10'd24, 10'd40, 10'd24});
	endtask : t_read_thresholds

	// Read-only word, then an unknown command that must be refused
	task automatic t_status_and_bad_cmd();
		logic [55:0] d;
		int          acks;
		u_m.read_reg(DEV, 8'hE0, d, acks);
		chk(56'(acks), 56'h3);
		chk(d, STATUS0);
		u_m.write_reg(DEV, 8'hE2, 56'h0, 0, acks);
		chk(56'(acks), 56'h1);
	endtask : t_status_and_bad_cmd

	task automatic t_truncated();
		int acks;
		u_m.write_reg(DEV, 8'hE5, 56'h123456789ABCDE, 3, acks);
		chk(56'(acks), 56'h5);
		chk({16'h0, t_iu, t_il, t_ou, t_ol}, {16'h0, 10'd40, 10'd24, 10'd40, 10'd24});
	endtask : t_truncated

	task automatic t_write_trim();
		int acks;
		u_m.write_reg(DEV, 8'hE4, 56'hA5A5A5_44332211, 7, acks);
		repeat (5) @(posedge clk);
		chk(56'(acks), 56'h9);
		chk({24'h0, vo, io, vi, ii}, 56'h44332211);
	endtask : t_write_trim

	// Strap order reversed gives 3, which must be ignored
	task automatic t_wrong_addr();
		int acks;
		u_m.write_reg(7'h03, 8'hE4, 56'h0, 7, acks);
		chk(56'(acks), 56'h0);
		chk({24'h0, vo, io, vi, ii}, 56'h44332211);
	endtask : t_wrong_addr

	initial begin
		clk = 1'b0;
		reset_n = 1'b0;
		strap = 3'h6;
		iin_s = 10'h0;
		iout_s = 10'h0;
		err_total = 0;
		compares = 0;
		repeat (10) @(posedge clk);
		reset_n <= 1'b1;
		repeat (5) @(posedge clk);
		t_reset_values();
		t_tracking();
		t_read_thresholds();
		t_status_and_bad_cmd();
		t_truncated();
		t_write_trim();
		t_wrong_addr();
		complete_run();
	end

	// About 87k clocks expected; cut off at 100k
	initial begin
		#4000000;
		err_total++;
		complete_run();
	end
endmodule : mppt_i2c_register_port_tb_top

bind mppt_i2c_register_port mppt_i2c_register_port_checker u_chk (.clk, .reset_n, .scl_in,
	.sda_out, .sda_oe, .vout_offset, .iout_offset, .vin_offset, .iin_offset,
	.input_current_start_upper, .input_current_start_lower, .output_current_start_upper,
	.output_current_start_lower, .input_current_sense_pin, .output_current_sense_pin,
	.tracking_enable);
